// file: verilog/irq_timebase_pkg.sv
// Package: register map, field layout, reset values, time-base constants and carrier structs
// Assumes: byte-addressed APB with 32-bit data, one register per aligned word
package irq_timebase_pkg;

    localparam int ADDR_W = 8;
    localparam int NUM_SRC = 8;
    localparam int NUM_MF = 4;
    localparam int NUM_VEC = 5;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_TIME_BASE_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SRC_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SRC_ENABLES = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h10;

    // time_base_control fields
    localparam int TBC_ON_BIT = 7;
    localparam int TBC_CK_BIT = 6;
    localparam int TBC_SECOND_LSB = 4;
    localparam int TBC_FIRST_LSB = 0;
    localparam logic [7:0] TBC_RESET = 8'h37;
    localparam logic [7:0] TBC_MASK = 8'hF7;

    // irq_control fields
    localparam int IC_GIE_BIT = 0;
    localparam int IC_SER_EN_BIT = 1;
    localparam int IC_SER_FLAG_BIT = 2;
    localparam int IC_MF_EN_LSB = 4;
    localparam int IC_MF_FLAG_LSB = 8;

    // Source order: tb0, tb1, nvm write done, low supply, t0 period, t0 second, t1 period, t1 second
    localparam int SRC_TB0 = 0;
    localparam int SRC_TB1 = 1;
    localparam int SRC_NVM = 2;
    localparam int SRC_LVD = 3;
    localparam int SRC_T0P = 4;
    localparam int SRC_T0A = 5;
    localparam int SRC_T1P = 6;
    localparam int SRC_T1A = 7;

    // Members of each shared vector
    localparam logic [NUM_MF-1:0][NUM_SRC-1:0] MF_MEMBERS = {8'h0C, 8'h03, 8'hC0, 8'h30};

    // Vector numbers, lower wins
    localparam logic [2:0] VEC_SERIAL = 3'h0;
    localparam logic [2:0] VEC_MF0 = 3'h1;

    // Time-base periods in input clocks
    localparam logic [15:0] FIRST_BASE_PERIOD = 16'h0100;
    localparam logic [15:0] SECOND_BASE_PERIOD = 16'h1000;
    localparam logic [1:0] SYS_DIV_LAST = 2'h3;

    typedef struct packed {
        logic boundary;
        logic stack_full;
        logic plain_return;
        logic return_from_handler;
    } core_in_t;

    typedef struct packed {
        logic call;
        logic push_pc;
        logic pop_pc;
        logic [2:0] vector;
    } core_out_t;

endpackage : irq_timebase_pkg

// file: verilog/period_divider.sv
// Time-base divider chain giving the two overflow pulses
// Assumes: tick is a one-cycle enable at the selected input rate
`timescale 1ns/1ps
`default_nettype none
module period_divider
    import irq_timebase_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic tick,
    input wire logic [2:0] first_sel,
    input wire logic [1:0] second_sel,
    // Overflow pulses
    output logic first_ovf,
    output logic second_ovf
);
    logic [14:0] count;
    logic [15:0] first_mask;
    logic [15:0] second_mask;

    assign first_mask = (FIRST_BASE_PERIOD << first_sel) - 16'h0001;
    assign second_mask = (SECOND_BASE_PERIOD << second_sel) - 16'h0001;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= 15'h0000;
        else if (!run)
            count <= 15'h0000;
        else if (tick)
            count <= count + 15'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_ovf <= 1'b0;
            second_ovf <= 1'b0;
        end
        else
        begin
            first_ovf <= run && tick && ((count & first_mask[14:0]) == first_mask[14:0]);
            second_ovf <= run && tick && ((count & second_mask[14:0]) == second_mask[14:0]);
        end
    end
endmodule : period_divider
`default_nettype wire

// file: verilog/peripheral_interrupt_timebase.sv
// Interrupt request, enable and vectoring logic with the periodic time base
// Assumes: APB master, core gives instruction boundaries and stack state as synchronous pulses/levels
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_timebase
    import irq_timebase_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time-base low-speed input tick
    input wire logic lowspeed_tick,
    // Event sources
    input wire logic [5:0] serial_cond,
    input wire logic nvm_write_end,
    input wire logic low_supply_detect,
    input wire logic [1:0] timer_period_match,
    input wire logic [1:0] timer_second_match,
    // Core sequencer
    input wire core_in_t core_in,
    output core_out_t core_out,
    output logic wake
);
    logic [7:0] time_base_control;
    logic global_irq_enable;
    logic serial_port_irq_enable;
    logic serial_port_irq_flag;
    logic [NUM_MF-1:0] shared_vector_enable;
    logic [NUM_MF-1:0] shared_vector_flag;
    logic [NUM_SRC-1:0] src_flag;
    logic [NUM_SRC-1:0] src_enable;
    logic [NUM_SRC-1:0] src_set;
    logic [NUM_MF-1:0] mf_set;
    logic [NUM_VEC-1:0] pend;
    logic [NUM_VEC-1:0] flags_now;
    logic [NUM_VEC+NUM_SRC-1:0] flags_q;
    logic serial_any_q;
    logic low_supply_q;
    logic [1:0] sys_div;
    logic period_tick;
    logic first_ovf;
    logic second_ovf;
    logic take;
    logic [2:0] next_vector;
    logic setup;
    logic access_wr;
    logic hit;
    logic [31:0] rd_mux;
    logic wr_tbc;
    logic wr_ic;
    logic wr_srcf;
    logic wr_srce;

    // Time-base input clock enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sys_div <= 2'h0;
        else
            sys_div <= sys_div + 2'h1;
    end

    // One tick per fourth clock, or the low-speed pin's own enable pulse
    assign period_tick = time_base_control[TBC_CK_BIT] ? (sys_div == SYS_DIV_LAST) : lowspeed_tick;

    // One divider chain serves both time bases
    period_divider u_period_divider (
        .pclk(pclk),
        .presetn(presetn),
        .run(time_base_control[TBC_ON_BIT]),
        .tick(period_tick),
        .first_sel(time_base_control[TBC_FIRST_LSB +: 3]),
        .second_sel(time_base_control[TBC_SECOND_LSB +: 2]),
        .first_ovf(first_ovf),
        .second_ovf(second_ovf)
    );

    // Edge capture of level sources: a held condition raises one request only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serial_any_q <= 1'b0;
        else
            serial_any_q <= |serial_cond;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_supply_q <= 1'b0;
        else
            low_supply_q <= low_supply_detect;
    end

    // One-cycle set requests from every source
    always_comb
    begin
        src_set = '0;
        src_set[SRC_TB0] = first_ovf;
        src_set[SRC_TB1] = second_ovf;
        src_set[SRC_NVM] = nvm_write_end;
        src_set[SRC_LVD] = low_supply_detect && !low_supply_q;
        src_set[SRC_T0P] = timer_period_match[0];
        src_set[SRC_T0A] = timer_second_match[0];
        src_set[SRC_T1P] = timer_period_match[1];
        src_set[SRC_T1A] = timer_second_match[1];
    end

    // APB decode
    // Writes land at the end of the access phase; unmapped ones are refused
    assign setup = psel && !penable;
    assign access_wr = psel && penable && pready && pwrite && !pslverr;
    assign wr_tbc = access_wr && (paddr == OFS_TIME_BASE_CONTROL);
    assign wr_ic = access_wr && (paddr == OFS_IRQ_CONTROL);
    assign wr_srcf = access_wr && (paddr == OFS_SRC_FLAGS);
    assign wr_srce = access_wr && (paddr == OFS_SRC_ENABLES);
    assign hit = (paddr == OFS_TIME_BASE_CONTROL) || (paddr == OFS_IRQ_CONTROL) || (paddr == OFS_SRC_FLAGS)
        || (paddr == OFS_SRC_ENABLES) || (paddr == OFS_PENDING);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_TIME_BASE_CONTROL: rd_mux[7:0] = time_base_control;
            OFS_IRQ_CONTROL:
            begin
                rd_mux[IC_GIE_BIT] = global_irq_enable;
                rd_mux[IC_SER_EN_BIT] = serial_port_irq_enable;
                rd_mux[IC_SER_FLAG_BIT] = serial_port_irq_flag;
                rd_mux[IC_MF_EN_LSB +: NUM_MF] = shared_vector_enable;
                rd_mux[IC_MF_FLAG_LSB +: NUM_MF] = shared_vector_flag;
            end
            OFS_SRC_FLAGS: rd_mux[NUM_SRC-1:0] = src_flag;
            OFS_SRC_ENABLES: rd_mux[NUM_SRC-1:0] = src_enable;
            OFS_PENDING: rd_mux[NUM_VEC-1:0] = pend;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Access-phase answer, one cycle after each setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !hit;
        end
    end

    // Read data captured in setup, held until the next read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

    // Time-base control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            time_base_control <= TBC_RESET;
        else if (wr_tbc)
            time_base_control <= pwdata[7:0] & TBC_MASK;
    end

    // Enables held in irq_control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_port_irq_enable <= 1'b0;
            shared_vector_enable <= '0;
        end
        else if (wr_ic)
        begin
            serial_port_irq_enable <= pwdata[IC_SER_EN_BIT];
            shared_vector_enable <= pwdata[IC_MF_EN_LSB +: NUM_MF];
        end
    end

    // Per-source enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            src_enable <= '0;
        else if (wr_srce)
            src_enable <= pwdata[NUM_SRC-1:0];
    end

    // Source flags: hardware set wins over software write; service never clears them
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_src
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    src_flag[gi] <= 1'b0;
                else if (src_set[gi])
                    src_flag[gi] <= 1'b1;
                else if (wr_srcf)
                    src_flag[gi] <= pwdata[gi];
            end
        end
        for (gi = 0; gi < NUM_MF; gi++)
        begin : g_mf
            assign mf_set[gi] = |(src_set & MF_MEMBERS[gi]);
            // Pending needs a member source that is itself flagged and enabled
            assign pend[gi+1] = shared_vector_flag[gi] && shared_vector_enable[gi]
                && (|(src_flag & src_enable & MF_MEMBERS[gi]));
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    shared_vector_flag[gi] <= 1'b0;
                else if (mf_set[gi])
                    shared_vector_flag[gi] <= 1'b1;
                else if (take && next_vector == VEC_MF0 + 3'(gi))
                    shared_vector_flag[gi] <= 1'b0;
                else if (wr_ic)
                    shared_vector_flag[gi] <= pwdata[IC_MF_FLAG_LSB + gi];
            end
        end
    endgenerate

    // Serial-port flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serial_port_irq_flag <= 1'b0;
        else if (|serial_cond && !serial_any_q)
            serial_port_irq_flag <= 1'b1;
        else if (take && next_vector == VEC_SERIAL)
            serial_port_irq_flag <= 1'b0;
        else if (wr_ic)
            serial_port_irq_flag <= pwdata[IC_SER_FLAG_BIT];
    end

    assign pend[0] = serial_port_irq_flag && serial_port_irq_enable;

    // Fixed priority: serial first, then shared vectors in index order
    always_comb
    begin
        next_vector = VEC_SERIAL;
        for (int i = NUM_VEC - 1; i >= 0; i--)
        begin
            if (pend[i])
                next_vector = 3'(i);
        end
    end

    // No new call while the previous one stands, so each service clears once
    assign take = core_in.boundary && global_irq_enable && !core_in.stack_full && (|pend)
        && !core_out.call;

    // Global enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            global_irq_enable <= 1'b0;
        else if (take)
            global_irq_enable <= 1'b0;
        else if (core_in.return_from_handler)
            global_irq_enable <= 1'b1;
        else if (wr_ic)
            global_irq_enable <= pwdata[IC_GIE_BIT];
    end

    // Core call and return strobes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_out <= '0;
        else
        begin
            core_out.call <= take;
            core_out.push_pc <= take;
            core_out.pop_pc <= core_in.return_from_handler || core_in.plain_return;
            if (take)
                core_out.vector <= next_vector;
        end
    end

    // Wake on any flag rising, independent of enables
    assign flags_now = {shared_vector_flag, serial_port_irq_flag};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= '0;
        else
            flags_q <= {src_flag, flags_now};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake <= 1'b0;
        else
            wake <= |({src_flag, flags_now} & ~flags_q);
    end
endmodule : peripheral_interrupt_timebase
`default_nettype wire

// file: tb/irq_checker.sv
// Checker: APB answer timing and call, push and pop behaviour at the block ports
// Assumes: bound into peripheral_interrupt_timebase, one clock domain
`timescale 1ns/1ps
`default_nettype none
module irq_checker
    import irq_timebase_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Core
    input wire core_in_t core_in,
    input wire core_out_t core_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_exit;
        core_in.plain_return || core_in.return_from_handler;
    endsequence
    property p_rdy; s_setup |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no pready");
    property p_rdy_src; pready |-> $past(psel && !penable); endproperty
    a_rdy_src: assert property (p_rdy_src) else $error("stray pready");
    property p_unmap; psel && !penable && paddr > 8'h10 |=> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("no pslverr");
    property p_push; core_out.push_pc == core_out.call; endproperty
    a_push: assert property (p_push) else $error("push apart from call");
    property p_take; core_out.call |-> $past(core_in.boundary && !core_in.stack_full); endproperty
    a_take: assert property (p_take) else $error("call not allowed");
    property p_once; core_out.call |=> !core_out.call; endproperty
    a_once: assert property (p_once) else $error("second call");
    property p_vec; core_out.call |-> core_out.vector <= 3'h4; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_pop; s_exit |=> core_out.pop_pc; endproperty
    a_pop: assert property (p_pop) else $error("no pop");
    property p_pop_src; core_out.pop_pc |-> $past(core_in.plain_return || core_in.return_from_handler); endproperty
    a_pop_src: assert property (p_pop_src) else $error("stray pop");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
endmodule : irq_checker
bind peripheral_interrupt_timebase irq_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .core_in(core_in),
    .core_out(core_out));
`default_nettype wire

// file: tb/core_model.sv
// Partner: core sequencer with call boundaries, a return stack and return strobes
// Assumes: the bench commands slow boundaries and returns
`timescale 1ns/1ps
`default_nettype none
module core_model
    import irq_timebase_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench commands
    input wire logic slow,
    input wire logic [1:0] exit_req,
    // Block side
    input wire core_out_t core_out,
    output var core_in_t core_in
);
    logic [1:0] phase;
    int depth;
    // Only the return address is stacked
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= 2'h0;
            depth <= 0;
        end
        else
        begin
            phase <= phase + 2'h1;
            depth <= depth + core_out.push_pc - core_out.pop_pc;
        end
    end
    // Slow mode offers one boundary per four-clock instruction
    assign core_in = '{boundary: !slow || phase == 2'h0, stack_full: depth >= DEPTH,
        plain_return: exit_req[0], return_from_handler: exit_req[1]};
endmodule : core_model
`default_nettype wire

// file: tb/tb.sv
// Testbench: registers, serial, time-base and shared-vector calls, wake and returns
// Assumes: core_model plays the core; the bench is APB master and event source
`timescale 1ns/1ps
`default_nettype none
module tb
    import irq_timebase_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic pready, pslverr, wake, e, hit;
    logic lt = 1'h0, nvm = 1'h0, lvd = 1'h0, slow = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [5:0] ser = 6'h00;
    logic [1:0] tp = 2'h0, ta = 2'h0, ex = 2'h0;
    core_in_t core_in;
    core_out_t core_out;
    int n, err_total = 0, comparisons = 0;
    peripheral_interrupt_timebase dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lowspeed_tick(lt), .serial_cond(ser), .nvm_write_end(nvm), .low_supply_detect(lvd),
        .timer_period_match(tp), .timer_second_match(ta), .core_in(core_in), .core_out(core_out), .wake(wake));
    core_model partner (.pclk(pclk), .presetn(presetn), .slow(slow), .exit_req(ex), .core_out(core_out),
        .core_in(core_in));
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) lt <= ~lt;
    task results;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task chk(input string s, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", s, x, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'h1 && i < 20);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
        if (pready !== 1'h1)
        begin
            err_total++;
            $display("BAD pready exp 1 got %b", pready);
            results;
        end
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk($sformatf("reg %h", a), x, q);
    endtask : rd
    task wt(input logic c, input int lim);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
            hit = c ? core_out.call : wake;
        end
        while (hit !== 1'h1 && n < lim);
    endtask : wt
    task vec(input logic [2:0] v);
        wt(1'h1, 1100);
        chk("call", {28'h0, 1'h1, v}, {28'h0, hit, core_out.vector});
        if (hit !== 1'h1)
            results;
    endtask : vec
    task quit(input logic [1:0] k);
        @(posedge pclk);
        ex <= k;
        @(posedge pclk);
        ex <= 2'h0;
    endtask : quit
    task t_regs;
        rd(8'h00, 32'h37);
        apb(1'h1, 8'h00, 32'hFF);
        rd(8'h00, 32'hF7);
        apb(1'h1, 8'h00, 32'h37);
        rd(8'h14, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
    endtask : t_regs
    task t_serial;
        slow <= 1'h1;
        apb(1'h1, 8'h04, 32'h3);
        for (int k = 0; k < 6; k++)
        begin
            ser <= 6'h01 << k;
            vec(3'h0);
            ser <= 6'h00;
            rd(8'h04, 32'h2);
            quit(k == 5 ? 2'h1 : 2'h2);
            rd(8'h04, k == 5 ? 32'h2 : 32'h3);
        end
        slow <= 1'h0;
    endtask : t_serial
    // Wake spacing equals the period once the flag is cleared in time
    task t_period(input logic [7:0] c, input int p);
        apb(1'h1, 8'h00, {24'h0, c});
        wt(1'h0, p + 20);
        chk("first", 32'h1, {31'h0, hit});
        apb(1'h1, 8'h08, 32'h0);
        wt(1'h0, p + 20);
        chk("period", p - 3, n);
        apb(1'h1, 8'h00, 32'h0);
        apb(1'h1, 8'h08, 32'h0);
        wt(1'h0, 2 * p);
        chk("stopped", 32'h0, {31'h0, hit});
    endtask : t_period
    // Second base overflows 3840 low-speed ticks (two clocks each) after the first base's first overflow
    task t_second;
        apb(1'h1, 8'h00, 32'h80);
        wt(1'h0, 600);
        chk("first", 32'h1, {31'h0, hit});
        wt(1'h0, 8000);
        chk("second", 32'h1E00, n);
        rd(8'h08, 32'h3);
        apb(1'h1, 8'h00, 32'h0);
        apb(1'h1, 8'h08, 32'h0);
    endtask : t_second
    task t_tb;
        apb(1'h1, 8'h0C, 32'h1);
        apb(1'h1, 8'h04, 32'h41);
        apb(1'h1, 8'h00, 32'hC0);
        vec(3'h3);
        rd(8'h04, 32'h40);
        rd(8'h08, 32'h1);
        apb(1'h1, 8'h00, 32'h0);
        apb(1'h1, 8'h08, 32'h0);
        quit(2'h1);
    endtask : t_tb
    task t_mf;
        apb(1'h1, 8'h04, 32'h0);
        // Second pulse finds the flag already set
        for (int k = 0; k < 2; k++)
        begin
            nvm <= 1'h1;
            @(posedge pclk);
            nvm <= 1'h0;
            wt(1'h0, 5);
            chk("wake", k == 0, {31'h0, hit});
        end
        {lvd, tp, ta} <= 5'h16;
        @(posedge pclk);
        {tp, ta} <= 4'h0;
        wt(1'h1, 20);
        chk("masked", 32'h0, {31'h0, hit});
        rd(8'h08, 32'h9C);
        rd(8'h04, 32'hB00);
        apb(1'h1, 8'h0C, 32'h9C);
        apb(1'h1, 8'h04, 32'hBF1);
        vec(3'h1);
        rd(8'h04, 32'hAF0);
        rd(8'h08, 32'h9C);
        apb(1'h1, 8'h04, 32'hAF1);
        vec(3'h2);
        apb(1'h1, 8'h04, 32'h8F1);
        wt(1'h1, 20);
        chk("full", 32'h0, {31'h0, hit});
        quit(2'h2);
        vec(3'h4);
        quit(2'h1);
        quit(2'h1);
        rd(8'h04, 32'h0F0);
        lvd <= 1'h0;
    endtask : t_mf
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_serial;
        t_period(8'h80, 512);
        t_period(8'hC1, 2048);
        t_second;
        t_tb;
        t_mf;
        results;
    end
endmodule : tb
`default_nettype wire
